// >>> verilog/ctpwm_params.svh
// Constants for the compact timer: register offsets, fields, reset values, clock dividers
`ifndef CTPWM_PARAMS_SVH
`define CTPWM_PARAMS_SVH
`define CTPWM_OFS_CTL_A 3'h0
`define CTPWM_OFS_CTL_B 3'h1
`define CTPWM_OFS_CNT_LO 3'h2
`define CTPWM_OFS_CNT_HI 3'h3
`define CTPWM_OFS_CMP_LO 3'h4
`define CTPWM_OFS_CMP_HI 3'h5
`define CTPWM_OFS_FLAGS 3'h6
`define CTPWM_RST_BYTE 8'h00
`define CTPWM_RST_CNT 10'h000
`define CTPWM_CNT_MAX 10'h3ff
`define CTPWM_HIGH_ZERO 6'h00
`define CTPWM_DIV_SYS4 8'h03
`define CTPWM_DIV_H16 8'h0f
`define CTPWM_DIV_H64 8'h3f
`define CTPWM_DIV_SUB_DEF 8'hff
`define CTPWM_P_SHIFT 7
`endif

// >>> verilog/ctpwm_pkg.sv
// Types for the compact timer: control register layouts and mode encodings
package ctpwm_pkg;
	typedef enum logic [1:0] {
		CTPWM_MODE_CMP = 2'h0,
		CTPWM_MODE_UNDEF = 2'h1,
		CTPWM_MODE_PWM = 2'h2,
		CTPWM_MODE_TMR = 2'h3
	} ctpwm_mode_t;
	typedef struct packed {
		logic pause_ctl;
		logic [2:0] clk_sel;
		logic counter_on;
		logic [2:0] period_match_bits;
	} ctpwm_ctl_a_t;
	typedef struct packed {
		ctpwm_mode_t mode_sel;
		logic [1:0] pin_action;
		logic initial_level;
		logic polarity_invert;
		logic period_duty_swap;
		logic clear_select;
	} ctpwm_ctl_b_t;
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} ctpwm_bus_t;
endpackage

// >>> verilog/ctpwm_timer.sv
// Compact 10-bit timer with compare-match and PWM output, byte register port
`timescale 1ns/10ps
`include "ctpwm_params.svh"
//
// Contract
// - Pause holds counter, resumes from held value
// - Clock select picks one of five tick sources
// - On rising edge clears counter, then runs
// - On cleared stops counter, keeps residual value
// - On rising edge restores initial pin level outside PWM mode
// - Period value compared with counter bits 9:7
// - Clear select high clears on A match
// - Clear select low clears on P/overflow
// - Clear select ignored in PWM mode
// - Mode field picks compare, PWM or timer
// - In compare mode, A match drives pin per pin action
// - PWM pin action forces level or waveform
// - Matching fixed level leaves pin unchanged
// - Initial level sets start level or activity
// - Polarity bit inverts pin outside timer mode
// - Swap bit exchanges period and duty roles
// - Counter readable only, split low/high bytes
// - Upper six high-byte bits read zero
// - Every register resets to zero except the inverted pin, which resets high
// - Low write buffers; high write commits both
// - High read latches low into buffer
// - A or P match raises its flag; P only in PWM mode or with clear select low
// - Inverted pin always complements primary pin
module ctpwm_timer #(
	parameter logic [7:0] SUB_DIV = `CTPWM_DIV_SUB_DEF
)(
	input wire logic clk,
	input wire logic rst,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	output logic timer_out_pin,
	output logic timer_out_pin_inv,
	output logic match_a_flag,
	output logic match_p_flag
);
	ctpwm_pkg::ctpwm_ctl_a_t ctl_a;
	ctpwm_pkg::ctpwm_ctl_b_t ctl_b;
	ctpwm_pkg::ctpwm_bus_t bus;
	logic [9:0] count;
	logic [9:0] a_compare_value;
	logic [7:0] byte_buf;
	logic [7:0] div_cnt;
	logic on_d;
	logic pin_state;
	logic [9:0] next_count;
	logic next_pin_state;
	logic [7:0] next_rdata;

	assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

	function automatic logic [7:0] hi_byte(input logic [9:0] v);
		hi_byte = {`CTPWM_HIGH_ZERO, v[9:8]};
	endfunction

	// Register decode
	wire wr_a = bus.wr && bus.addr == `CTPWM_OFS_CTL_A;
	wire wr_b = bus.wr && bus.addr == `CTPWM_OFS_CTL_B;
	wire wr_cmp_lo = bus.wr && bus.addr == `CTPWM_OFS_CMP_LO;
	wire wr_cmp_hi = bus.wr && bus.addr == `CTPWM_OFS_CMP_HI;
	wire wr_flags = bus.wr && bus.addr == `CTPWM_OFS_FLAGS;
	wire rd_cnt_hi = bus.rd && bus.addr == `CTPWM_OFS_CNT_HI;
	wire rd_cmp_hi = bus.rd && bus.addr == `CTPWM_OFS_CMP_HI;

	// Tick source: divider enable pulses, all from the one clock
	wire [7:0] div_top = (ctl_a.clk_sel == 3'h0) ? `CTPWM_DIV_SYS4 :
		(ctl_a.clk_sel == 3'h2) ? `CTPWM_DIV_H16 :
		(ctl_a.clk_sel == 3'h3) ? `CTPWM_DIV_H64 : SUB_DIV;
	wire sel_valid = ctl_a.clk_sel <= 3'h5;
	wire sel_direct = ctl_a.clk_sel == 3'h1;
	wire tick = sel_valid && (sel_direct || div_cnt >= div_top);
	wire on_rise = ctl_a.counter_on && !on_d;
	wire run = ctl_a.counter_on && !ctl_a.pause_ctl && tick;

	// Comparators; the counter value being matched is the one about to be
	// entered, so a match period equals the value in ticks
	wire [9:0] cnt_inc = count + 10'h001;
	wire [2:0] p_hi = cnt_inc[9:`CTPWM_P_SHIFT];
	wire p_zero = ctl_a.period_match_bits == 3'h0;
	wire ovf = count == `CTPWM_CNT_MAX;
	wire p_hit = p_zero ? ovf : (p_hi == ctl_a.period_match_bits &&
		cnt_inc[`CTPWM_P_SHIFT-1:0] == 7'h00);
	wire a_zero = a_compare_value == `CTPWM_RST_CNT;
	wire a_hit = !a_zero && cnt_inc == a_compare_value;
	wire is_pwm = ctl_b.mode_sel == ctpwm_pkg::CTPWM_MODE_PWM;
	wire is_cmp = ctl_b.mode_sel == ctpwm_pkg::CTPWM_MODE_CMP;
	wire per_a = is_pwm ? ctl_b.period_duty_swap : ctl_b.clear_select;
	wire clr_hit = per_a ? (a_hit || (a_zero && ovf)) : p_hit;
	wire ev_a = run && a_hit;
	wire ev_p = run && p_hit && (is_pwm || !ctl_b.clear_select);

	// PWM duty: active while counter is below the duty value
	wire [10:0] duty_val = ctl_b.period_duty_swap ?
		(p_zero ? 11'h400 : {1'b0, ctl_a.period_match_bits, 7'h00}) :
		{1'b0, a_compare_value};
	wire pwm_active = {1'b0, count} < duty_val;
	wire pwm_level = pwm_active ? ctl_b.initial_level : !ctl_b.initial_level;

	always_comb
	begin
		next_count = count;
		if (on_rise)
			next_count = `CTPWM_RST_CNT;
		else if (run)
			next_count = clr_hit ? `CTPWM_RST_CNT : cnt_inc;
	end

	always_comb
	begin
		next_pin_state = pin_state;
		if (on_rise && !is_pwm)
			next_pin_state = ctl_b.initial_level;
		else if (is_cmp && ev_a)
		begin
			// Fixed-level actions equal to the present level change nothing
			case (ctl_b.pin_action)
				2'h1: next_pin_state = 1'b0;
				2'h2: next_pin_state = 1'b1;
				2'h3: next_pin_state = !pin_state;
				default: next_pin_state = pin_state;
			endcase
		end
		else if (is_pwm)
		begin
			case (ctl_b.pin_action)
				2'h0: next_pin_state = !ctl_b.initial_level;
				2'h1: next_pin_state = ctl_b.initial_level;
				2'h2: next_pin_state = pwm_level;
				default: next_pin_state = pin_state;
			endcase
		end
	end

	// Timer mode: pin undefined, chosen to hold low without polarity
	wire pin_final = (ctl_b.mode_sel == ctpwm_pkg::CTPWM_MODE_TMR) ? 1'b0 :
		(next_pin_state ^ ctl_b.polarity_invert);

	always_comb
	begin
		case (bus.addr)
			`CTPWM_OFS_CTL_A: next_rdata = ctl_a;
			`CTPWM_OFS_CTL_B: next_rdata = ctl_b;
			`CTPWM_OFS_CNT_LO: next_rdata = byte_buf;
			`CTPWM_OFS_CNT_HI: next_rdata = hi_byte(count);
			`CTPWM_OFS_CMP_LO: next_rdata = byte_buf;
			`CTPWM_OFS_CMP_HI: next_rdata = hi_byte(a_compare_value);
			`CTPWM_OFS_FLAGS: next_rdata = {6'h00, match_p_flag, match_a_flag};
			default: next_rdata = `CTPWM_RST_BYTE;
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ctl_a <= `CTPWM_RST_BYTE;
			ctl_b <= `CTPWM_RST_BYTE;
			count <= `CTPWM_RST_CNT;
			a_compare_value <= `CTPWM_RST_CNT;
			byte_buf <= `CTPWM_RST_BYTE;
			div_cnt <= `CTPWM_RST_BYTE;
			on_d <= 1'b0;
			pin_state <= 1'b0;
			rdata <= `CTPWM_RST_BYTE;
			timer_out_pin <= 1'b0;
			timer_out_pin_inv <= 1'b1;
			match_a_flag <= 1'b0;
			match_p_flag <= 1'b0;
		end
		else
		begin
			if (wr_a)
				ctl_a <= bus.wdata;
			if (wr_b)
				ctl_b <= bus.wdata;
			if (wr_cmp_lo)
				byte_buf <= bus.wdata;
			else if (rd_cnt_hi)
				byte_buf <= count[7:0];
			else if (rd_cmp_hi)
				byte_buf <= a_compare_value[7:0];
			if (wr_cmp_hi)
				a_compare_value <= {bus.wdata[1:0], byte_buf};
			// Prescaler restarts with the counter so the first tick is one full period away
			div_cnt <= (tick || !sel_valid || on_rise) ? `CTPWM_RST_BYTE : div_cnt + 8'h01;
			on_d <= ctl_a.counter_on;
			count <= next_count;
			pin_state <= next_pin_state;
			rdata <= bus.rd ? next_rdata : `CTPWM_RST_BYTE;
			timer_out_pin <= pin_final;
			timer_out_pin_inv <= !pin_final;
			// Set wins over a same-cycle write-one clear
			match_a_flag <= ev_a || (match_a_flag && !(wr_flags && bus.wdata[0]));
			match_p_flag <= ev_p || (match_p_flag && !(wr_flags && bus.wdata[1]));
		end
	end

	a_pin_complement: assert property (@(posedge clk) disable iff (rst)
		timer_out_pin_inv == !timer_out_pin)
		else $error("inverted pin not complement");
	a_pause_hold: assert property (@(posedge clk) disable iff (rst)
		ctl_a.pause_ctl && !on_rise |=> count == $past(count))
		else $error("counter moved while paused");
	a_off_hold: assert property (@(posedge clk) disable iff (rst)
		!ctl_a.counter_on |=> count == $past(count))
		else $error("counter moved while off");
	a_on_clear: assert property (@(posedge clk) disable iff (rst)
		on_rise |=> count == `CTPWM_RST_CNT)
		else $error("counter not cleared on enable");
	a_count_step: assert property (@(posedge clk) disable iff (rst)
		run && !on_rise && !clr_hit |=> count == $past(count) + 10'h001)
		else $error("counter did not step");
	a_clear_a: assert property (@(posedge clk) disable iff (rst)
		run && !on_rise && !is_pwm && ctl_b.clear_select && a_hit |=> count == 10'h000)
		else $error("A match did not clear");
	a_clear_p: assert property (@(posedge clk) disable iff (rst)
		run && !on_rise && !is_pwm && !ctl_b.clear_select && p_hit |=> count == 10'h000)
		else $error("P match did not clear");
	a_flag_a: assert property (@(posedge clk) disable iff (rst)
		ev_a |=> match_a_flag)
		else $error("A flag not raised");
	a_high_zero: assert property (@(posedge clk) disable iff (rst)
		$past(rd_cnt_hi) |-> rdata[7:2] == 6'h00)
		else $error("high byte upper bits not zero");
	a_cmp_commit: assert property (@(posedge clk) disable iff (rst)
		wr_cmp_hi |=> a_compare_value == {$past(bus.wdata[1:0]), $past(byte_buf)})
		else $error("compare commit wrong");
	a_toggle_pin: assert property (@(posedge clk) disable iff (rst)
		is_cmp && ev_a && !on_rise && ctl_b.pin_action == 2'h3 |=> pin_state != $past(pin_state))
		else $error("toggle missed");
	a_flag_p: assert property (@(posedge clk) disable iff (rst)
		ev_p
		|=> match_p_flag)
		else $error("P flag not raised");
	a_flag_a_keep: assert property (@(posedge clk) disable iff (rst)
		match_a_flag && !(wr_flags && bus.wdata[0])
		|=> match_a_flag)
		else $error("A flag dropped");
	a_flag_p_keep: assert property (@(posedge clk) disable iff (rst)
		match_p_flag && !(wr_flags && bus.wdata[1])
		|=> match_p_flag)
		else $error("P flag dropped");
	a_flag_a_clear: assert property (@(posedge clk) disable iff (rst)
		wr_flags && bus.wdata[0] && !ev_a
		|=> !match_a_flag)
		else $error("A flag not cleared");
	a_flag_p_clear: assert property (@(posedge clk) disable iff (rst)
		wr_flags && bus.wdata[1] && !ev_p
		|=> !match_p_flag)
		else $error("P flag not cleared");
	a_no_p_flag: assert property (@(posedge clk) disable iff (rst)
		!is_pwm && ctl_b.clear_select && !match_p_flag
		|=> !match_p_flag)
		else $error("P flag raised with A clear");
	a_zero_a_flag: assert property (@(posedge clk) disable iff (rst)
		a_zero && !match_a_flag
		|=> !match_a_flag)
		else $error("A flag raised with zero compare");
	a_ctl_a_write: assert property (@(posedge clk) disable iff (rst)
		wr_a
		|=> ctl_a == $past(bus.wdata))
		else $error("control A write lost");
	a_ctl_b_write: assert property (@(posedge clk) disable iff (rst)
		wr_b
		|=> ctl_b == $past(bus.wdata))
		else $error("control B write lost");
	a_buf_write: assert property (@(posedge clk) disable iff (rst)
		wr_cmp_lo
		|=> byte_buf == $past(bus.wdata))
		else $error("low byte not buffered");
	a_low_only: assert property (@(posedge clk) disable iff (rst)
		wr_cmp_lo
		|=> a_compare_value == $past(a_compare_value))
		else $error("low write reached compare");
	a_cnt_latch: assert property (@(posedge clk) disable iff (rst)
		rd_cnt_hi && !bus.wr
		|=> byte_buf == $past(count[7:0]))
		else $error("count low not latched");
	a_cmp_latch: assert property (@(posedge clk) disable iff (rst)
		rd_cmp_hi && !bus.wr
		|=> byte_buf == $past(a_compare_value[7:0]))
		else $error("compare low not latched");
	a_rdata_idle: assert property (@(posedge clk) disable iff (rst)
		!bus.rd
		|=> rdata == `CTPWM_RST_BYTE)
		else $error("read data not idle");
	a_rd_cnt_low: assert property (@(posedge clk) disable iff (rst)
		bus.rd && bus.addr == `CTPWM_OFS_CNT_LO
		|=> rdata == $past(byte_buf))
		else $error("count low read wrong");
	a_rd_cmp_low: assert property (@(posedge clk) disable iff (rst)
		bus.rd && bus.addr == `CTPWM_OFS_CMP_LO
		|=> rdata == $past(byte_buf))
		else $error("compare low read wrong");
	a_rd_cnt_high: assert property (@(posedge clk) disable iff (rst)
		rd_cnt_hi
		|=> rdata == {`CTPWM_HIGH_ZERO, $past(count[9:8])})
		else $error("count high read wrong");
	a_rd_cmp_high: assert property (@(posedge clk) disable iff (rst)
		rd_cmp_hi
		|=> rdata == {`CTPWM_HIGH_ZERO, $past(a_compare_value[9:8])})
		else $error("compare high read wrong");
	a_rd_ctl_a: assert property (@(posedge clk) disable iff (rst)
		bus.rd && bus.addr == `CTPWM_OFS_CTL_A
		|=> rdata == $past(ctl_a))
		else $error("control A read wrong");
	a_timer_pin: assert property (@(posedge clk) disable iff (rst)
		ctl_b.mode_sel == ctpwm_pkg::CTPWM_MODE_TMR
		|=> !timer_out_pin)
		else $error("pin active in timer mode");
	a_polarity_pin: assert property (@(posedge clk) disable iff (rst)
		ctl_b.mode_sel != ctpwm_pkg::CTPWM_MODE_TMR
		|=> timer_out_pin == ($past(next_pin_state) ^ $past(ctl_b.polarity_invert)))
		else $error("polarity not applied");
	a_on_level: assert property (@(posedge clk) disable iff (rst)
		on_rise && !is_pwm
		|=> pin_state == $past(ctl_b.initial_level))
		else $error("initial level not restored");
	a_pin_low: assert property (@(posedge clk) disable iff (rst)
		is_cmp && ev_a && !on_rise && ctl_b.pin_action == 2'h1
		|=> !pin_state)
		else $error("match did not drive low");
	a_pin_high: assert property (@(posedge clk) disable iff (rst)
		is_cmp && ev_a && !on_rise && ctl_b.pin_action == 2'h2
		|=> pin_state)
		else $error("match did not drive high");
	a_pin_keep: assert property (@(posedge clk) disable iff (rst)
		is_cmp && ev_a && !on_rise && ctl_b.pin_action == 2'h0
		|=> $stable(pin_state))
		else $error("no-change action moved pin");
	a_pwm_inactive: assert property (@(posedge clk) disable iff (rst)
		is_pwm && ctl_b.pin_action == 2'h0
		|=> pin_state == !$past(ctl_b.initial_level))
		else $error("PWM inactive force wrong");
	a_pwm_active: assert property (@(posedge clk) disable iff (rst)
		is_pwm && ctl_b.pin_action == 2'h1
		|=> pin_state == $past(ctl_b.initial_level))
		else $error("PWM active force wrong");
	a_pwm_wave: assert property (@(posedge clk) disable iff (rst)
		is_pwm && ctl_b.pin_action == 2'h2
		|=> pin_state == ($past(pwm_active) ? $past(ctl_b.initial_level) : !$past(ctl_b.initial_level)))
		else $error("PWM waveform level wrong");
	a_pwm_period_p: assert property (@(posedge clk) disable iff (rst)
		is_pwm && run && !on_rise && !ctl_b.period_duty_swap && p_hit
		|=> count == `CTPWM_RST_CNT)
		else $error("PWM period P clear missed");
	a_pwm_period_a: assert property (@(posedge clk) disable iff (rst)
		is_pwm && run && !on_rise && ctl_b.period_duty_swap && a_hit
		|=> count == `CTPWM_RST_CNT)
		else $error("PWM period A clear missed");
	a_reserved_hold: assert property (@(posedge clk) disable iff (rst)
		ctl_a.clk_sel > 3'h5 && !on_rise
		|=> count == $past(count))
		else $error("reserved clock ticked");
	a_div_restart: assert property (@(posedge clk) disable iff (rst)
		on_rise
		|=> div_cnt == `CTPWM_RST_BYTE)
		else $error("prescaler not restarted");
	a_ovf_clear: assert property (@(posedge clk) disable iff (rst)
		run && !on_rise && !per_a && p_zero && ovf
		|=> count == `CTPWM_RST_CNT)
		else $error("overflow did not clear");
	a_p_period: assert property (@(posedge clk) disable iff (rst)
		run && !on_rise && !per_a && !p_zero && count == {ctl_a.period_match_bits - 3'h1, 7'h7f}
		|=> count == `CTPWM_RST_CNT)
		else $error("period match missed");
endmodule

// >>> tb/tb_ctpwm_timer.sv
// Self-checking bench for the compact timer: registers, clocking, compare and PWM
`timescale 1ns/10ps
module tb_ctpwm_timer;
	logic clk, rst, wr, rd, timer_out_pin, timer_out_pin_inv, match_a_flag, match_p_flag;
	logic [2:0] addr;
	logic [7:0] wdata, rdata, v, g;
	logic [9:0] c1, c2;
	integer error_cnt, comparisons, seed, n, i;
	integer divs [0:5] = '{4, 1, 16, 64, 8, 8};
	logic [7:0] pwm_b [0:4] = '{8'ha8, 8'ha9, 8'haa, 8'h88, 8'h98};
	integer pwm_hi [0:4] = '{32, 32, 128, 0, 128};
	logic [3:0] pa_exp = 4'b1100;
	ctpwm_timer #(.SUB_DIV(8'h07)) u_ctpwm_timer (.clk(clk), .rst(rst), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .timer_out_pin(timer_out_pin),
		.timer_out_pin_inv(timer_out_pin_inv), .match_a_flag(match_a_flag),
		.match_p_flag(match_p_flag));
	initial
	begin
		clk = 0;
		forever #20 clk = ~clk;
	end
	function automatic integer period_of(input integer p, input integer d);
		period_of = (p == 0 ? 1024 : p * 128) * d;
	endfunction
	task automatic results;
		$display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		comparisons = comparisons + 1;
		if (got !== exp)
		begin
			error_cnt = error_cnt + 1;
			$display("Error at %0t: value %h, expected %h", $time, got, exp);
		end
	endtask
	// Tolerance covers the register-port latency around start and sampling
	task automatic chk_near(input integer got, input integer exp);
		comparisons = comparisons + 1;
		if (got < exp - 4 || got > exp + 4)
		begin
			error_cnt = error_cnt + 1;
			$display("Error at %0t: count %0d, expected %0d", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	// High byte first so the low byte comes from the same snapshot
	task automatic rd_cnt(output logic [9:0] c);
		rd_reg(3'h3, g);
		chk8(g & 8'hfc, 8'h00);
		c[9:8] = g[1:0];
		rd_reg(3'h2, g);
		c[7:0] = g;
	endtask
	task automatic wait_flag(input logic p, output integer k);
		k = 0;
		while (((p ? match_p_flag : match_a_flag) !== 1'b1) && k < 20000)
		begin
			@(posedge clk);
			#1 k = k + 1;
		end
		if (k >= 20000)
		begin
			error_cnt = error_cnt + 1;
			$display("Error at %0t: flag wait timed out", $time);
			results;
		end
	endtask
	task automatic restart(input logic [7:0] b, input logic [7:0] a);
		wr_reg(3'h0, 8'h00);
		wr_reg(3'h1, b);
		wr_reg(3'h6, 8'h03);
		wr_reg(3'h0, a);
	endtask
	initial
	begin
		seed = 60;
		error_cnt = 0;
		comparisons = 0;
		rst = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 3'h0;
		wdata = 8'h00;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		chk8({timer_out_pin, timer_out_pin_inv}, 8'h01);
		for (i = 0; i < 8; i++)
		begin
			rd_reg(i[2:0], v);
			chk8(v, 8'h00);
		end
		$display("Reset test done");
		repeat (4)
		begin
			v = $random(seed);
			wr_reg(3'h1, v);
			rd_reg(3'h1, g);
			chk8(g, v);
			wr_reg(3'h0, v & 8'hf7);
			rd_reg(3'h0, g);
			chk8(g, v & 8'hf7);
			wr_reg(3'h4, v);
			wr_reg(3'h5, ~v);
			rd_reg(3'h5, g);
			chk8(g, ~v & 8'h03);
			rd_reg(3'h4, g);
			chk8(g, v);
		end
		$display("Register test done");
		for (i = 0; i < 6; i++)
		begin
			restart(8'h00, {1'b0, i[2:0], 4'h9});
			wait_flag(1'b1, n);
			chk_near(n, period_of(1, divs[i]));
		end
		restart(8'h00, 8'h18);
		wait_flag(1'b1, n);
		chk_near(n, period_of(0, 1));
		restart(8'h00, 8'h69);
		repeat (100) @(posedge clk);
		rd_cnt(c1);
		chk8(c1[7:0], 8'h00);
		$display("Clock test done");
		restart(8'h00, 8'h18);
		repeat (40) @(posedge clk);
		wr_reg(3'h0, 8'h98);
		rd_cnt(c1);
		repeat (20) @(posedge clk);
		rd_cnt(c2);
		chk8(c2[7:0], c1[7:0]);
		wr_reg(3'h0, 8'h18);
		repeat (10) @(posedge clk);
		rd_cnt(c2);
		chk8({7'h0, c2 > c1}, 8'h01);
		wr_reg(3'h0, 8'h10);
		rd_cnt(c1);
		repeat (20) @(posedge clk);
		rd_cnt(c2);
		chk8({7'h0, c2 === c1 && c1 > 10'h0}, 8'h01);
		wr_reg(3'h0, 8'h18);
		rd_cnt(c2);
		chk8({7'h0, c2 < 10'h8}, 8'h01);
		$display("Pause test done");
		wr_reg(3'h4, 8'h32);
		wr_reg(3'h5, 8'h00);
		for (i = 0; i < 4; i++)
		begin
			restart({2'b00, i[1:0], 4'h1}, 8'h18);
			@(posedge clk);
			#1;
			chk8({timer_out_pin, timer_out_pin_inv}, 8'h01);
			wait_flag(1'b0, n);
			chk_near(n, 50);
			repeat (2) @(posedge clk);
			chk8({match_p_flag, timer_out_pin, timer_out_pin_inv},
				{5'h0, 1'b0, pa_exp[i], ~pa_exp[i]});
		end
		restart(8'h25, 8'h18);
		repeat (2) @(posedge clk);
		chk8({timer_out_pin, timer_out_pin_inv}, 8'h02);
		restart(8'he1, 8'h18);
		wait_flag(1'b0, n);
		chk_near(n, 50);
		$display("Compare test done");
		wr_reg(3'h4, 8'h20);
		wr_reg(3'h5, 8'h00);
		for (i = 0; i < 5; i++)
		begin
			restart(pwm_b[i], 8'h19);
			repeat (200) @(posedge clk);
			n = 0;
			repeat (128)
			begin
				@(posedge clk);
				#1 n = n + (timer_out_pin === 1'b1 ? 1 : 0);
			end
			chk_near(n, pwm_hi[i]);
		end
		$display("PWM test done");
		results;
	end
endmodule
